/* File: rtl/sbc_defs.svh */
`ifndef SBC_DEFS_SVH
`define SBC_DEFS_SVH

// ----------------------------------------
// Widths and structure
// ----------------------------------------
`define SBC_SAMP_W 16
`define SBC_TAPS 4
`define SBC_BANDS 32
`define SBC_BAND_W 5
`define SBC_BIT_LAST 4'hF
`define SBC_BAND_LAST 5'h1F
`define SBC_COEF_SHIFT 14
`define SBC_RQ8_SHIFT 8
`define SBC_MAX16 17'sh07FFF
`define SBC_MIN16 17'sh18000
`define SBC_MAX8 17'sh0007F
`define SBC_MIN8 17'sh1FF80
`define SBC_WIN_LAST 8'hFF
`define SBC_TICK_W 25
`define SBC_SEC_W 7

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SBC_OFF_CTRL 8'h00
`define SBC_OFF_SEL 8'h04
`define SBC_OFF_FREQ 8'h08
`define SBC_OFF_GAIN 8'h0C
`define SBC_OFF_THRESH 8'h10
`define SBC_OFF_POWER 8'h14
`define SBC_OFF_TIME 8'h18
`define SBC_OFF_STATUS 8'h1C
`define SBC_OFF_MASK 8'h20
`define SBC_OFF_COEF 8'h40
`define SBC_COEF_MASK 8'hF0

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define SBC_CTRL_EN 0
`define SBC_CTRL_RES16 1
`define SBC_ST_RFI 0
`define SBC_ST_SAT 1
`define SBC_ST_PPS 2
`define SBC_CTRL_RST 2'h1
`define SBC_SEL_RST 32'hFFFFFFFF
`define SBC_GAIN_RST 16'h4000
`define SBC_COEF0_RST 16'h4000
`define SBC_THRESH_RST 32'hFFFFFFFF

`endif

/* File: rtl/sbc_pkg.sv */
package sbc_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } sbc_bus_s;

    typedef struct packed {
        logic valid;
        logic sop;
        logic eop;
        logic [31:0] data;
    } sbc_pkt_s;

    typedef enum logic [1:0] {
        SBC_IDLE = 2'b00,
        SBC_HDR = 2'b01,
        SBC_DATA = 2'b10
    } sbc_pkt_e;

endpackage : sbc_pkg

/* File: rtl/sbc_requant.sv */
`timescale 1ns/100ps
`include "sbc_defs.svh"

module sbc_requant (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Sub-band sample in
    input wire logic in_valid,
    input wire logic signed [16:0] in_data,
    input wire logic [4:0] in_band,
    input wire logic res16,
    // Requantized sample out
    output logic out_valid,
    output logic [15:0] out_data,
    output logic [4:0] out_band,
    output logic out_sat
);
    import sbc_pkg::*;

    logic signed [16:0] scaled;
    logic signed [16:0] hi_lim;
    logic signed [16:0] lo_lim;
    logic signed [16:0] clip_next;
    logic sat_next;

    always_comb
    begin
        scaled = res16 ? in_data : (in_data >>> `SBC_RQ8_SHIFT);
        hi_lim = res16 ? `SBC_MAX16 : `SBC_MAX8;
        lo_lim = res16 ? `SBC_MIN16 : `SBC_MIN8;
        clip_next = scaled;
        sat_next = 1'b0;
        if (scaled > hi_lim)
        begin
            clip_next = hi_lim;
            sat_next = 1'b1;
        end
        else if (scaled < lo_lim)
        begin
            clip_next = lo_lim;
            sat_next = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_valid <= 1'b0;
            out_data <= 16'h0000;
            out_band <= 5'h00;
            out_sat <= 1'b0;
        end
        else
        begin
            out_valid <= in_valid;
            out_sat <= in_valid & sat_next;
            if (in_valid)
            begin
                out_data <= clip_next[15:0];
                out_band <= in_band;
            end
        end
    end

    sat_eight_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        in_valid && !res16 && ((in_data >>> `SBC_RQ8_SHIFT) > `SBC_MAX8)
        |=> out_data == 16'h007F && out_sat)
        else $error("8-bit overflow not clipped");

    pass_wide_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        in_valid && res16 && (in_data[16] == in_data[15])
        |=> out_data == $past(in_data[15:0]) && !out_sat)
        else $error("16-bit sample altered");

endmodule : sbc_requant

/* File: rtl/sbc_top.sv */
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`include "sbc_defs.svh"

// Summary of operation
// - FIR filter corrects sideband leakage
// - FIR coefficients stored, software can overwrite
// - Apply software-loaded bandpass gain equalization
// - Frequency shift removes LO offset
// - Polyphase bank splits into 32 sub-bands
// - Requantize to 8 bits, 16 optional
// - Timestamp and packetize sub-band data
// - Send only software-selected sub-bands
// - Local time derived from timing input
// - Monitor power, flag interference, report

module sbc_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Serial link from digitizer_module
    input wire logic ser_data,
    input wire logic ser_frame,
    // Second pulse from antenna_timing_source
    input wire logic pps_in,
    // Register port
    input wire sbc_pkg::sbc_bus_s bus,
    output logic [31:0] rdata,
    // Packets toward subband_processor
    output sbc_pkg::sbc_pkt_s pkt,
    // Interrupt
    output logic irq
);
    import sbc_pkg::*;

    function automatic logic coef_hit(input logic [7:0] a);
        return (a & `SBC_COEF_MASK) == `SBC_OFF_COEF;
    endfunction : coef_hit

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [1:0] sd_sync_reg;
    logic [1:0] sf_sync_reg;
    logic [1:0] pps_sync_reg;
    logic pps_prev_reg;
    logic pps_rise;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sd_sync_reg <= 2'h0;
            sf_sync_reg <= 2'h0;
            pps_sync_reg <= 2'h0;
            pps_prev_reg <= 1'b0;
        end
        else
        begin
            sd_sync_reg <= {sd_sync_reg[0], ser_data};
            sf_sync_reg <= {sf_sync_reg[0], ser_frame};
            pps_sync_reg <= {pps_sync_reg[0], pps_in};
            pps_prev_reg <= pps_sync_reg[1];
        end
    end

    assign pps_rise = pps_sync_reg[1] & ~pps_prev_reg;

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    logic [1:0] ctrl_reg;
    logic [31:0] sel_reg;
    logic [15:0] freq_reg;
    logic signed [15:0] gain_reg;
    logic [31:0] thresh_reg;
    logic [2:0] mask_reg;
    logic signed [15:0] coef_reg [0:`SBC_TAPS-1];

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_reg <= `SBC_CTRL_RST;
            sel_reg <= `SBC_SEL_RST;
            freq_reg <= 16'h0000;
            gain_reg <= `SBC_GAIN_RST;
            thresh_reg <= `SBC_THRESH_RST;
            mask_reg <= 3'h0;
        end
        else if (bus.wr)
        begin
            case (bus.addr)
                `SBC_OFF_CTRL: ctrl_reg <= bus.wdata[1:0];
                `SBC_OFF_SEL: sel_reg <= bus.wdata;
                `SBC_OFF_FREQ: freq_reg <= bus.wdata[15:0];
                `SBC_OFF_GAIN: gain_reg <= bus.wdata[15:0];
                `SBC_OFF_THRESH: thresh_reg <= bus.wdata;
                `SBC_OFF_MASK: mask_reg <= bus.wdata[2:0];
                default: ;
            endcase
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `SBC_TAPS; gi++)
        begin : g_coef
            always_ff @(posedge clk_sys or negedge rst_n)
            begin
                if (!rst_n)
                    coef_reg[gi] <= (gi == 0) ? `SBC_COEF0_RST : 16'h0000;
                else if (bus.wr && coef_hit(bus.addr) && bus.addr[3:2] == 2'(gi))
                    coef_reg[gi] <= bus.wdata[15:0];
            end
        end
    endgenerate

    // ----------------------------------------
    // Serial sample receiver
    // ----------------------------------------
    logic [15:0] shift_reg;
    logic [3:0] bitcnt_reg;
    logic s0_valid_reg;
    logic signed [15:0] s0_reg;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shift_reg <= 16'h0000;
            bitcnt_reg <= 4'h0;
            s0_valid_reg <= 1'b0;
            s0_reg <= 16'h0000;
        end
        else
        begin
            s0_valid_reg <= 1'b0;
            if (sf_sync_reg[1])
            begin
                shift_reg <= {shift_reg[14:0], sd_sync_reg[1]};
                bitcnt_reg <= bitcnt_reg + 4'h1;
                if (bitcnt_reg == `SBC_BIT_LAST)
                begin
                    s0_reg <= {shift_reg[14:0], sd_sync_reg[1]};
                    s0_valid_reg <= ctrl_reg[`SBC_CTRL_EN];
                end
            end
            else
                bitcnt_reg <= 4'h0;
        end
    end

    // ----------------------------------------
    // Sideband FIR and gain equalizer
    // ----------------------------------------
    logic signed [15:0] xd_reg [0:`SBC_TAPS-2];
    logic signed [15:0] tap [0:`SBC_TAPS-1];
    logic signed [31:0] prod [0:`SBC_TAPS-1];
    logic signed [33:0] fir_sum;
    logic signed [31:0] gprod;
    logic fir_valid_reg;
    logic signed [15:0] fir_reg;
    logic g_valid_reg;
    logic signed [15:0] g_reg;

    generate
        for (gi = 0; gi < `SBC_TAPS; gi++)
        begin : g_tap
            if (gi == 0)
            begin : g_first
                assign tap[gi] = s0_reg;
            end
            else
            begin : g_rest
                assign tap[gi] = xd_reg[gi-1];
            end
            assign prod[gi] = tap[gi] * coef_reg[gi];
        end
    endgenerate

    always_comb
    begin
        fir_sum = 34'sh0;
        for (int i = 0; i < `SBC_TAPS; i++)
            fir_sum = fir_sum + 34'(prod[i]);
    end

    assign gprod = fir_reg * gain_reg;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fir_valid_reg <= 1'b0;
            fir_reg <= 16'h0000;
            for (int i = 0; i < `SBC_TAPS-1; i++)
                xd_reg[i] <= 16'h0000;
        end
        else
        begin
            fir_valid_reg <= s0_valid_reg;
            if (s0_valid_reg)
            begin
                fir_reg <= fir_sum[`SBC_COEF_SHIFT +: `SBC_SAMP_W];
                xd_reg[0] <= s0_reg;
                for (int i = 1; i < `SBC_TAPS-1; i++)
                    xd_reg[i] <= xd_reg[i-1];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            g_valid_reg <= 1'b0;
            g_reg <= 16'h0000;
        end
        else
        begin
            g_valid_reg <= fir_valid_reg;
            if (fir_valid_reg)
                g_reg <= gprod[`SBC_COEF_SHIFT +: `SBC_SAMP_W];
        end
    end

    // ----------------------------------------
    // Frequency shift
    // ----------------------------------------
    logic [15:0] phase_reg;
    logic mix_valid_reg;
    logic signed [15:0] mix_reg;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_reg <= 16'h0000;
            mix_valid_reg <= 1'b0;
            mix_reg <= 16'h0000;
        end
        else
        begin
            mix_valid_reg <= g_valid_reg;
            if (g_valid_reg)
            begin
                phase_reg <= phase_reg + freq_reg;
                case (phase_reg[15:14])
                    2'b00: mix_reg <= g_reg;
                    2'b10: mix_reg <= -g_reg;
                    default: mix_reg <= 16'h0000;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Polyphase bank
    // ----------------------------------------
    logic signed [15:0] hist_mem [0:`SBC_BANDS-1];
    logic [4:0] band_reg;
    logic pfb_valid_reg;
    logic signed [16:0] pfb_reg;
    logic [4:0] pfb_band_reg;

    // Cleared on reset so the first frame adds no stale history
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < `SBC_BANDS; i++)
                hist_mem[i] <= 16'h0000;
        end
        else if (mix_valid_reg)
            hist_mem[band_reg] <= mix_reg;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            band_reg <= 5'h00;
            pfb_valid_reg <= 1'b0;
            pfb_reg <= 17'h00000;
            pfb_band_reg <= 5'h00;
        end
        else
        begin
            pfb_valid_reg <= mix_valid_reg;
            if (mix_valid_reg)
            begin
                pfb_reg <= 17'(mix_reg) + 17'(hist_mem[band_reg]);
                pfb_band_reg <= band_reg;
                band_reg <= band_reg + 5'h01;
            end
        end
    end

    // ----------------------------------------
    // Requantizer
    // ----------------------------------------
    logic rq_valid;
    logic [15:0] rq_data;
    logic [4:0] rq_band;
    logic rq_sat;

    sbc_requant u_requant (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(pfb_valid_reg),
        .in_data(pfb_reg),
        .in_band(pfb_band_reg),
        .res16(ctrl_reg[`SBC_CTRL_RES16]),
        .out_valid(rq_valid),
        .out_data(rq_data),
        .out_band(rq_band),
        .out_sat(rq_sat)
    );

    // ----------------------------------------
    // Local time reference
    // ----------------------------------------
    logic [`SBC_TICK_W-1:0] tick_reg;
    logic [`SBC_SEC_W-1:0] sec_reg;

    // ticks restart on each timing pulse
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_reg <= '0;
            sec_reg <= '0;
        end
        else if (pps_rise)
        begin
            tick_reg <= '0;
            sec_reg <= sec_reg + `SBC_SEC_W'(1);
        end
        else
            tick_reg <= tick_reg + `SBC_TICK_W'(1);
    end

    // ----------------------------------------
    // Packetizer
    // ----------------------------------------
    sbc_pkt_e state_reg;
    sbc_pkt_s pkt_reg;
    logic [15:0] hold_data_reg;
    logic [4:0] hold_band_reg;

    // header word with timestamp, then data
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= SBC_IDLE;
            pkt_reg <= '0;
            hold_data_reg <= 16'h0000;
            hold_band_reg <= 5'h00;
        end
        else
        begin
            pkt_reg <= '0;
            case (state_reg)
                SBC_IDLE:
                    if (rq_valid && sel_reg[rq_band])
                    begin
                        hold_data_reg <= rq_data;
                        hold_band_reg <= rq_band;
                        state_reg <= SBC_HDR;
                    end
                SBC_HDR:
                begin
                    pkt_reg.valid <= 1'b1;
                    pkt_reg.sop <= 1'b1;
                    pkt_reg.data <= {hold_band_reg, ctrl_reg[`SBC_CTRL_RES16],
                                     sec_reg[0], tick_reg};
                    state_reg <= SBC_DATA;
                end
                SBC_DATA:
                begin
                    pkt_reg.valid <= 1'b1;
                    pkt_reg.eop <= 1'b1;
                    pkt_reg.data <= {{16{hold_data_reg[15]}}, hold_data_reg};
                    state_reg <= SBC_IDLE;
                end
                default: state_reg <= SBC_IDLE;
            endcase
        end
    end

    assign pkt = pkt_reg;

    // ----------------------------------------
    // Power and interference monitor
    // ----------------------------------------
    logic [31:0] pwr_acc_reg;
    logic [7:0] win_reg;
    logic [31:0] power_reg;
    logic rfi_ev_reg;
    logic [31:0] pwr_sum;

    // Magnitude kept unsigned so the most negative sample counts as 8000
    assign pwr_sum = pwr_acc_reg + {16'h0000, (g_reg[15] ? -g_reg : g_reg)};

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwr_acc_reg <= 32'h00000000;
            win_reg <= 8'h00;
            power_reg <= 32'h00000000;
            rfi_ev_reg <= 1'b0;
        end
        else
        begin
            rfi_ev_reg <= 1'b0;
            if (g_valid_reg)
            begin
                win_reg <= win_reg + 8'h01;
                pwr_acc_reg <= pwr_sum;
                if (win_reg == `SBC_WIN_LAST)
                begin
                    power_reg <= pwr_sum;
                    pwr_acc_reg <= 32'h00000000;
                    rfi_ev_reg <= pwr_sum > thresh_reg;
                end
            end
        end
    end

    // ----------------------------------------
    // Status, interrupt and read-back
    // ----------------------------------------
    logic [2:0] status_reg;
    logic [2:0] events;
    logic [2:0] clr;

    assign events = {pps_rise, rq_sat, rfi_ev_reg};
    assign clr = (bus.wr && bus.addr == `SBC_OFF_STATUS) ? bus.wdata[2:0] : 3'h0;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            status_reg <= 3'h0;
        else
            status_reg <= (status_reg & ~clr) | events;
    end

    assign irq = |(status_reg & mask_reg);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= 32'h00000000;
        else if (!bus.rd)
            rdata <= 32'h00000000;
        else if (coef_hit(bus.addr))
            rdata <= 32'(coef_reg[bus.addr[3:2]]);
        else
            case (bus.addr)
                `SBC_OFF_CTRL: rdata <= {30'h0, ctrl_reg};
                `SBC_OFF_SEL: rdata <= sel_reg;
                `SBC_OFF_FREQ: rdata <= {16'h0000, freq_reg};
                `SBC_OFF_GAIN: rdata <= {16'h0000, gain_reg};
                `SBC_OFF_THRESH: rdata <= thresh_reg;
                `SBC_OFF_POWER: rdata <= power_reg;
                `SBC_OFF_TIME: rdata <= {sec_reg, tick_reg};
                `SBC_OFF_STATUS: rdata <= {29'h0, status_reg};
                `SBC_OFF_MASK: rdata <= {29'h0, mask_reg};
                default: rdata <= 32'h00000000;
            endcase
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    fir_stage_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s0_valid_reg |=> fir_valid_reg ##1 g_valid_reg ##1 mix_valid_reg)
        else $error("Filter pipeline lost a sample");

    coef_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        bus.wr && bus.addr == `SBC_OFF_COEF
        |=> coef_reg[0] == $past(bus.wdata[15:0]))
        else $error("Coefficient write not stored");

    mix_null_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        g_valid_reg && phase_reg[14] |=> mix_reg == 16'h0000)
        else $error("Mixer quadrature phase not zero");

    band_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mix_valid_reg && band_reg == 5'h1F |=> band_reg == 5'h00)
        else $error("Branch counter did not wrap at 32");

    hdr_data_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pkt.valid && pkt.sop |=> pkt.valid && pkt.eop && !pkt.sop)
        else $error("Header not followed by data word");

    sel_only_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pkt.valid && pkt.sop |-> sel_reg[pkt.data[31:27]])
        else $error("Unselected sub-band sent");

    time_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pps_rise |=> tick_reg == '0 ##1 tick_reg == 25'h0000001 || pps_rise)
        else $error("Local time not realigned");

    rfi_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rfi_ev_reg |=> status_reg[0] && power_reg > thresh_reg)
        else $error("Interference not flagged");

    pkt_sent_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        pkt.valid && pkt.eop);
    rfi_seen_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        rfi_ev_reg);
    sat_seen_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        rq_sat ##1 irq);

endmodule : sbc_top

/* File: verification/sbc_dig_model.sv */
`timescale 1ns/100ps

module sbc_dig_model (
    // Clock
    input wire logic clk_sys,
    // Serial link
    output logic ser_data,
    output logic ser_frame
);
    initial
    begin
        ser_data = 1'b0;
        ser_frame = 1'b0;
    end

    task automatic send(input logic [15:0] x);
        for (int i = 15; i >= 0; i--)
        begin
            @(posedge clk_sys);
            ser_frame <= 1'b1;
            ser_data <= x[i];
        end
    endtask : send

    // Released line toggles so a stale bit never looks valid
    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            ser_frame <= 1'b0;
            ser_data <= ~ser_data;
        end
    endtask : idle
endmodule : sbc_dig_model

/* File: verification/subband_channelizer_test.sv */
`timescale 1ns/100ps
`include "sbc_defs.svh"

module subband_channelizer_test;
    import sbc_pkg::*;
    // ----
    // Signals
    // ----
    logic clk_sys, rst_n, pps_in, rd_d, sop_d, irq, ser_data, ser_frame, sat;
    sbc_bus_s bus;
    logic [31:0] rdata, sel;
    sbc_pkt_s pkt;
    int failures, compares, cycles, seed, idx, pw;
    logic [31:0] rq[$], dq[$];
    logic [5:0] hq[$];
    logic signed [16:0] prev[32];
    logic [15:0] x, ph, freq;

    sbc_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .ser_data(ser_data),
        .ser_frame(ser_frame), .pps_in(pps_in), .bus(bus), .rdata(rdata),
        .pkt(pkt), .irq(irq));
    sbc_dig_model dig_u (.clk_sys(clk_sys), .ser_data(ser_data), .ser_frame(ser_frame));

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic give_verdict;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys);
        bus <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        rq.push_back(e);
        @(posedge clk_sys);
        bus <= '0;
    endtask : rd

    // Unity FIR and gain; mixer by phase quadrant; band sum is m plus last m of band
    task automatic stream(input int n, input logic res);
        logic signed [16:0] s;
        logic [15:0] m;
        int v, hi, xi;
        for (int k = 0; k < n; k++)
        begin
            x = $random(seed);
            xi = $signed(x);
            pw += (xi < 0) ? -xi : xi;
            m = (ph[15:14] == 2'b00) ? x : (ph[15:14] == 2'b10) ? -x : 16'h0000;
            ph += freq;
            s = $signed(m) + prev[idx];
            prev[idx] = $signed(m);
            if (!res)
                s = s >>> 8;
            hi = res ? 32767 : 127;
            v = s;
            v = (v > hi) ? hi : (v < -hi - 1) ? -hi - 1 : v;
            sat |= (v != s);
            if (sel[idx])
            begin
                hq.push_back({idx[4:0], res});
                dq.push_back(v);
            end
            idx = (idx + 1) % 32;
            dig_u.send(x);
        end
    endtask : stream

    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        rd_d <= bus.rd;
        sop_d <= pkt.valid & pkt.sop;
        if (rd_d)
            cmp(rdata, rq.size() ? rq.pop_front() : 32'hX);
        if (pkt.valid & pkt.sop)
            cmp({26'h0, pkt.data[31:26]}, hq.size() ? {26'h0, hq.pop_front()} : 32'hX);
        if (pkt.valid & pkt.eop)
        begin
            cmp({31'h0, sop_d}, 32'h1);
            cmp(pkt.data, dq.size() ? dq.pop_front() : 32'hX);
        end
        if (cycles == 10000)
        begin
            failures++;
            give_verdict();
        end
    end

    initial
    begin
        seed = 56481;
        rst_n = 1'b0;
        pps_in = 1'b0;
        bus = '0;
        {idx, pw, failures, compares, cycles, rd_d, sop_d, sat, ph, freq} = '0;
        sel = 32'hFFFFFFFF;
        foreach (prev[i]) prev[i] = '0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(`SBC_OFF_CTRL, 32'h1);
        rd(`SBC_OFF_SEL, 32'hFFFFFFFF);
        rd(`SBC_OFF_GAIN, 32'h4000);
        rd(`SBC_OFF_COEF, 32'h4000);
        rd(8'h44, 32'h0);
        rd(`SBC_OFF_STATUS, 32'h0);
        wr(8'h3C, 32'h1234);
        rd(8'h3C, 32'h0);
        wr(`SBC_OFF_COEF, 32'h4000);
        wr(8'h4C, 32'h1234);
        rd(8'h4C, 32'h1234);
        wr(8'h4C, 32'h0);
        rd(8'h4C, 32'h0);
        stream(70, 1'b0);
        dig_u.idle(40);
        sel = $random(seed);
        freq = 16'h4000;
        wr(`SBC_OFF_SEL, sel);
        wr(`SBC_OFF_FREQ, {16'h0000, freq});
        wr(`SBC_OFF_THRESH, 32'h0);
        wr(`SBC_OFF_CTRL, 32'h3);
        stream(186, 1'b1);
        dig_u.idle(40);
        rd(`SBC_OFF_SEL, sel);
        rd(`SBC_OFF_POWER, pw);
        rd(`SBC_OFF_STATUS, {30'h0, sat, 1'b1});
        #1 cmp({31'h0, irq}, 32'h0);
        wr(`SBC_OFF_MASK, 32'h2);
        #1 cmp({31'h0, irq}, {31'h0, sat});
        wr(`SBC_OFF_STATUS, 32'h2);
        #1 cmp({31'h0, irq}, 32'h0);
        @(posedge clk_sys);
        pps_in <= 1'b1;
        repeat (4) @(posedge clk_sys);
        pps_in <= 1'b0;
        rd(`SBC_OFF_STATUS, 32'h5);
        wr(`SBC_OFF_MASK, 32'h4);
        #1 cmp({31'h0, irq}, 32'h1);
        repeat (4) @(posedge clk_sys);
        cmp(hq.size() + dq.size() + rq.size(), 32'h0);
        give_verdict();
    end
endmodule : subband_channelizer_test
